// ===== src/reset_seq_cfg.svh
// constants for the reset and time-out sequencer
// assumes a 20 mhz reference clock and a byte-addressed register port
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_STATUS 4'h0
`define OFS_CTRL 4'h4
`define OFS_CFG 4'h8

// ****************************************
// control register fields and reset values
// ****************************************
`define CTRL_SLEEP_BIT 0
`define CTRL_KEEP_ACK_BIT 1
`define FLAG_RESET 1'b1

// ****************************************
// timing
// ****************************************
`define CLK_NS 50
`define CLK_MHZ 20
`define GLITCH_NS 200
`define GLITCH_CYC ((`GLITCH_NS + `CLK_NS - 1) / `CLK_NS)
`define BOR_QUAL_US 100
`define BOR_QUAL_CYC (`BOR_QUAL_US * `CLK_MHZ)
`define OST_CYCLES 1024
`define POWERUP_DELAY_TIMER_MS 72
`define RC_OSC_KHZ 1000
`define POWERUP_DELAY_TIMER_TICKS (`POWERUP_DELAY_TIMER_MS * `RC_OSC_KHZ)

`endif

// ===== src/reset_seq_pkg.sv
// types shared by the reset and time-out sequencer
// assumes nothing beyond a systemverilog compiler
package reset_seq_pkg;

    // oscillator mode field as stored in nonvolatile configuration
    typedef enum logic [1:0] {
        low_power_crystal_mode = 2'h0,
        standard_crystal_mode = 2'h1,
        high_speed_crystal_mode = 2'h2,
        resistor_capacitor_mode = 2'h3
    } osc_mode_e;

    // nonvolatile configuration bits seen by the sequencer
    typedef struct packed {
        logic brownout_enable_cfg;
        logic powerup_delay_enable_cfg;
        osc_mode_e osc_mode_select;
    } cfg_s;

    // one-hot cause of the last reset
    typedef enum logic [5:0] {
        cause_none = 6'h00,
        cause_power_on = 6'h01,
        cause_pin_run = 6'h02,
        cause_pin_sleep = 6'h04,
        cause_watchdog_run = 6'h08,
        cause_watchdog_wake = 6'h10,
        cause_brownout = 6'h20
    } cause_e;

    // gray-coded sequencer: hold -> delay -> startup -> run
    typedef enum logic [1:0] {
        st_hold = 2'h0,
        st_powerup_delay_timer = 2'h1,
        st_ost = 2'h3,
        st_run = 2'h2
    } seq_state_e;

    // status word layout, low bits of the status register
    typedef struct packed {
        seq_state_e state;
        logic keep_valid;
        logic powerdown_flag;
        logic timeout_flag;
        cause_e cause;
    } status_s;

endpackage

// ===== src/reset_timeout_sequencer.sv
// reset source arbiter and power-up time-out sequencer for an 8-bit core
// assumes synchronous inputs on ref_clk, an rc tick and an oscillator input
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_cfg.svh"

module reset_timeout_sequencer import reset_seq_pkg::*; #(
    parameter int powerup_delay_timer_ticks = `POWERUP_DELAY_TIMER_TICKS
) (
    // clock and block reset
    input wire logic ref_clk,
    input wire logic nrst,
    // reset sources
    input wire logic supply_rise,
    input wire logic low_supply,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_timeout,
    // timing sources
    input wire logic rc_osc_tick,
    input wire logic oscillator_input_pin,
    // nonvolatile configuration
    input wire cfg_s cfg,
    // register port
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // reset outputs toward the core
    output logic core_reset,
    output logic regs_init
);

    // ****************************************
    // helpers
    // ****************************************

    // crystal modes need the startup count, rc mode never does
    function automatic logic is_crystal(input osc_mode_e m);
        return m != resistor_capacitor_mode;
    endfunction

    // ****************************************
    // pin filter and brown-out qualifier
    // ****************************************

    logic [2:0] glitch_cnt, next_glitch_cnt;
    logic pin_rst, next_pin_rst;
    logic [11:0] bor_cnt, next_bor_cnt;
    logic bor_active, next_bor_active;
    logic osc_q, next_osc_q;
    logic osc_edge;

    // the pin is only ever read here; nothing drives it back
    always_comb begin
        next_glitch_cnt = 3'h0;
        next_pin_rst = 1'b0;
        if (!external_reset_pin_n) begin
            next_pin_rst = pin_rst;
            if (glitch_cnt == 3'(`GLITCH_CYC - 1)) begin
                next_pin_rst = 1'b1;
                next_glitch_cnt = glitch_cnt;
            end else begin
                next_glitch_cnt = glitch_cnt + 3'h1;
            end
        end
        // dips shorter than the qualify time are forgotten
        next_bor_cnt = 12'h000;
        next_bor_active = 1'b0;
        if (low_supply && cfg.brownout_enable_cfg) begin
            next_bor_active = bor_active;
            if (bor_cnt == 12'(`BOR_QUAL_CYC - 1)) begin
                next_bor_active = 1'b1;
                next_bor_cnt = bor_cnt;
            end else begin
                next_bor_cnt = bor_cnt + 12'h001;
            end
        end
        next_osc_q = oscillator_input_pin;
    end

    // a resonator or a driven clock both give rising edges here
    assign osc_edge = oscillator_input_pin & ~osc_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            glitch_cnt <= 3'h0;
            pin_rst <= 1'b0;
            bor_cnt <= 12'h000;
            bor_active <= 1'b0;
            osc_q <= 1'b0;
        end else begin
            glitch_cnt <= next_glitch_cnt;
            pin_rst <= next_pin_rst;
            bor_cnt <= next_bor_cnt;
            bor_active <= next_bor_active;
            osc_q <= next_osc_q;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************

    seq_state_e state, next_state;
    cause_e cause, next_cause;
    logic [23:0] powerup_delay_timer_cnt, next_powerup_delay_timer_cnt;
    logic [9:0] ost_cnt, next_ost_cnt;
    logic need_powerup_delay_timer, next_need_powerup_delay_timer;
    logic need_ost, next_need_ost;
    logic timeout_flag, next_timeout_flag;
    logic powerdown_flag, next_powerdown_flag;
    logic sleeping, next_sleeping;
    logic keep_valid, next_keep_valid;
    logic por_pending, next_por_pending;
    logic next_regs_init, next_core_reset;
    logic powerup_delay_timer_on, por_req, ctrl_wr, wake;

    // brown-out enable overrides the active-low delay enable
    assign powerup_delay_timer_on = !cfg.powerup_delay_enable_cfg
                     || cfg.brownout_enable_cfg;
    assign por_req = supply_rise || por_pending;
    assign wake = watchdog_timeout && sleeping && state == st_run;

    // priority: power-on, brown-out, pin, watchdog
    always_comb begin
        next_state = state;
        next_cause = cause;
        next_powerup_delay_timer_cnt = powerup_delay_timer_cnt;
        next_ost_cnt = ost_cnt;
        next_need_powerup_delay_timer = need_powerup_delay_timer;
        next_need_ost = need_ost;
        next_timeout_flag = timeout_flag;
        next_powerdown_flag = powerdown_flag;
        next_sleeping = sleeping;
        next_keep_valid = keep_valid;
        next_regs_init = regs_init;
        next_por_pending = 1'b0;
        // software enters sleep or marks keep-class contents valid
        if (ctrl_wr && avs_byteenable[0]) begin
            if (avs_writedata[`CTRL_SLEEP_BIT]) begin
                next_sleeping = 1'b1;
                next_timeout_flag = 1'b1;
                next_powerdown_flag = 1'b0;
            end
            if (avs_writedata[`CTRL_KEEP_ACK_BIT]) begin
                next_keep_valid = 1'b1;
            end
        end
        if (por_req) begin
            next_state = st_hold;
            next_cause = cause_power_on;
            next_timeout_flag = 1'b1;
            next_powerdown_flag = 1'b1;
            next_keep_valid = 1'b0;
            next_regs_init = 1'b1;
            next_need_powerup_delay_timer = powerup_delay_timer_on;
            next_need_ost = is_crystal(cfg.osc_mode_select);
            next_sleeping = 1'b0;
            next_powerup_delay_timer_cnt = 24'h0;
            next_ost_cnt = 10'h0;
        end else if (bor_active) begin
            next_state = st_hold;
            next_cause = cause_brownout;
            next_timeout_flag = 1'b1;
            next_powerdown_flag = 1'b1;
            next_regs_init = 1'b1;
            next_need_powerup_delay_timer = 1'b1;
            next_need_ost = 1'b0;
            next_sleeping = 1'b0;
            next_powerup_delay_timer_cnt = 24'h0;
            next_ost_cnt = 10'h0;
        end else if (pin_rst && state == st_run) begin
            next_state = st_hold;
            next_regs_init = 1'b1;
            next_sleeping = 1'b0;
            if (sleeping) begin
                next_cause = cause_pin_sleep;
                next_timeout_flag = 1'b1;
                next_powerdown_flag = 1'b0;
                next_need_ost = is_crystal(cfg.osc_mode_select);
            end else begin
                next_cause = cause_pin_run;
            end
        end else if (wake) begin
            // wake-up resumes execution: no register init
            next_cause = cause_watchdog_wake;
            next_timeout_flag = 1'b0;
            next_powerdown_flag = 1'b0;
            next_sleeping = 1'b0;
            next_ost_cnt = 10'h0;
            if (is_crystal(cfg.osc_mode_select)) begin
                next_state = st_ost;
            end
        end else if (watchdog_timeout && state == st_run) begin
            // internal only; the pin stays an input
            next_cause = cause_watchdog_run;
            next_timeout_flag = 1'b0;
            next_powerdown_flag = 1'b1;
            next_regs_init = 1'b1;
            next_state = st_hold;
        end else begin
            unique case (state)
                st_hold: begin
                    if (need_powerup_delay_timer) begin
                        next_state = st_powerup_delay_timer;
                    end else if (need_ost) begin
                        next_state = st_ost;
                    end else begin
                        next_state = st_run;
                    end
                end
                st_powerup_delay_timer: begin
                    if (rc_osc_tick) begin
                        next_powerup_delay_timer_cnt = powerup_delay_timer_cnt + 24'h1;
                    end
                    if (powerup_delay_timer_cnt == 24'(powerup_delay_timer_ticks)) begin
                        next_need_powerup_delay_timer = 1'b0;
                        next_powerup_delay_timer_cnt = 24'h0;
                        next_state = need_ost ? st_ost : st_run;
                    end
                    // a fresh dip after brown-out restarts the whole delay
                    if (low_supply && cfg.brownout_enable_cfg
                        && cause == cause_brownout) begin
                        next_powerup_delay_timer_cnt = 24'h0;
                        next_need_powerup_delay_timer = 1'b1;
                        next_state = st_powerup_delay_timer;
                    end
                end
                st_ost: begin
                    if (osc_edge) begin
                        next_ost_cnt = ost_cnt + 10'h1;
                        if (ost_cnt == 10'(`OST_CYCLES - 1)) begin
                            next_need_ost = 1'b0;
                            next_ost_cnt = 10'h0;
                            next_state = st_run;
                        end
                    end
                end
                st_run: begin
                    next_regs_init = 1'b0;
                end
            endcase
        end
        // the pin still holds the core even while timers run out
        next_core_reset = next_state == st_hold || next_state == st_powerup_delay_timer
                          || next_state == st_ost || pin_rst
                          || bor_active || por_req;
    end

    // release happens on a ref_clk edge only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= st_hold;
            cause <= cause_none;
            powerup_delay_timer_cnt <= 24'h0;
            ost_cnt <= 10'h0;
            need_powerup_delay_timer <= 1'b0;
            need_ost <= 1'b0;
            timeout_flag <= `FLAG_RESET;
            powerdown_flag <= `FLAG_RESET;
            sleeping <= 1'b0;
            keep_valid <= 1'b0;
            por_pending <= 1'b1;
            regs_init <= 1'b1;
            core_reset <= 1'b1;
        end else begin
            state <= next_state;
            cause <= next_cause;
            powerup_delay_timer_cnt <= next_powerup_delay_timer_cnt;
            ost_cnt <= next_ost_cnt;
            need_powerup_delay_timer <= next_need_powerup_delay_timer;
            need_ost <= next_need_ost;
            timeout_flag <= next_timeout_flag;
            powerdown_flag <= next_powerdown_flag;
            sleeping <= next_sleeping;
            keep_valid <= next_keep_valid;
            por_pending <= next_por_pending;
            regs_init <= next_regs_init;
            core_reset <= next_core_reset;
        end
    end

    // ****************************************
    // register port
    // ****************************************

    logic ack, next_ack;
    logic [31:0] next_readdata;
    status_s status;

    assign status = '{state: state, keep_valid: keep_valid,
                      powerdown_flag: powerdown_flag,
                      timeout_flag: timeout_flag, cause: cause};
    // one wait state on every access keeps read data registered
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign ctrl_wr = avs_write && ack && avs_address == `OFS_CTRL;

    always_comb begin
        next_ack = (avs_read || avs_write) && !ack;
        next_readdata = avs_readdata;
        if (avs_read && !ack) begin
            unique case (avs_address)
                `OFS_STATUS: next_readdata = 32'(status);
                `OFS_CTRL: next_readdata = 32'(sleeping);
                `OFS_CFG: next_readdata = 32'(cfg);
                default: next_readdata = 32'h0; // unmapped reads as zero
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack <= next_ack;
            avs_readdata <= next_readdata;
        end
    end

    // ****************************************
    // checks
    // ****************************************

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_pin_low4;
        !external_reset_pin_n [*4];
    endsequence

    sequence s_ost_last;
        state == st_ost && !bor_active && !por_req && !pin_rst
        && osc_edge && ost_cnt == 10'h3ff;
    endsequence

    a_glitch_long: assert property (s_pin_low4 |=> pin_rst)
        else $error("long pin low not taken as reset");
    a_glitch_short: assert property ($rose(pin_rst) |->
        $past(!external_reset_pin_n, 4))
        else $error("pin reset taken on a short pulse");
    a_bor_qualify: assert property ($rose(bor_active) |->
        $past(bor_cnt) == 12'd1999)
        else $error("brown-out taken before qualify time");
    a_bor_stays: assert property (bor_active && low_supply
        && cfg.brownout_enable_cfg |=> bor_active)
        else $error("brown-out released while supply low");
    a_bor_delay: assert property ($fell(bor_active) && !por_req
        |-> need_powerup_delay_timer && state == st_hold)
        else $error("no power-up delay after brown-out");
    a_powerup_delay_timer_hold: assert property (state == st_powerup_delay_timer |-> core_reset)
        else $error("core released during power-up delay");
    a_ost_end: assert property (s_ost_last |=> state == st_run)
        else $error("startup count end not 1024 edges");
    a_rc_skip: assert property (state == st_hold && !need_powerup_delay_timer
        && cfg.osc_mode_select == resistor_capacitor_mode && !por_req
        && !bor_active |=> state != st_ost)
        else $error("startup count used in rc mode");
    a_wake_keep: assert property (wake && !por_req && !bor_active
        && !pin_rst |=> !regs_init && !timeout_flag)
        else $error("watchdog wake-up reloaded registers");
    a_por_flags: assert property (nrst && por_req |=> timeout_flag
        && powerdown_flag && cause == cause_power_on && core_reset)
        else $error("power-on flags wrong");

endmodule
`default_nettype wire

// ===== tb/osc_model.sv
// rc tick and oscillator input model for the sequencer bench
// assumes the bench supplies ref_clk and nrst
`timescale 1ns/1ps
`default_nettype none

module osc_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // timing outputs
    output logic rc_osc_tick,
    output logic oscillator_input_pin
);
    logic [1:0] div;

    // ****************************************
    // free-running sources
    // ****************************************
    // tick every fourth cycle, so the delay is slow enough to measure
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div <= 2'h0;
            rc_osc_tick <= 1'b0;
            oscillator_input_pin <= 1'b0;
        end else begin
            div <= div + 2'h1;
            rc_osc_tick <= (div == 2'h3);
            oscillator_input_pin <= !oscillator_input_pin;
        end
    end
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the reset and time-out sequencer
// assumes osc_model drives the rc tick and oscillator input
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_cfg.svh"

module testbench import reset_seq_pkg::*; ;
    logic ref_clk, nrst, supply_rise, low_supply, pin_n, wdt;
    logic tick, osc, core_reset, regs_init, kv;
    cfg_s cfg;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, q;
    int miscompares, n_checks, cyc, n;

    osc_model i_osc (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .rc_osc_tick(tick),
        .oscillator_input_pin(osc)
    );

    // short delay count keeps the run brief
    reset_timeout_sequencer #(.powerup_delay_timer_ticks(10)) i_dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .supply_rise(supply_rise),
        .low_supply(low_supply),
        .external_reset_pin_n(pin_n),
        .watchdog_timeout(wdt),
        .rc_osc_tick(tick),
        .oscillator_input_pin(osc),
        .cfg(cfg),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .core_reset(core_reset),
        .regs_init(regs_init)
    );

    // ****************************************
    // helpers
    // ****************************************
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, s, e);
        end
    endtask

    // one access; held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        // data taken and request dropped at the edge that ends the wait
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // cycles until core_reset reaches v, bounded by mx
    task wt(input logic v, input int mx);
        n = 0;
        while (core_reset !== v && n < mx) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // number of cycles out of c with core_reset high
    task mon(input int c);
        n = 0;
        repeat (c) begin
            @(negedge ref_clk);
            if (core_reset === 1'b1) n++;
        end
    endtask

    task stat(input cause_e c, input logic to, input logic pd);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk({21'h0, q[10:0]}, {21'h0, st_run, kv, pd, to, c});
    endtask

    task wdog;
        @(posedge ref_clk);
        wdt <= 1'b1;
        @(posedge ref_clk);
        wdt <= 1'b0;
    endtask

    task pin_hold(input int k);
        @(posedge ref_clk);
        pin_n <= 1'b0;
        repeat (k) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(core_reset, 1'b1);
        chk(regs_init, 1'b1);
        @(posedge ref_clk);
        pin_n <= 1'b1;
    endtask

    task sleep;
        bus(1'b1, `OFS_CTRL, 32'h1);
        bus(1'b0, `OFS_CTRL, 32'h0);
        chk(q[0], 1'b1);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_power_on;
        wt(1'b0, 4000);
        chk(32'(n >= 2080 && n < 4000), 32'h1);
        stat(cause_power_on, 1'b1, 1'b1);
    endtask

    task t_bus;
        bus(1'b0, `OFS_CFG, 32'h0);
        chk(q, {28'h0, cfg});
        bus(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, `OFS_CTRL, 32'h2);
        kv = 1'b1;
    endtask

    task t_pin_run;
        @(posedge ref_clk);
        pin_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        pin_n <= 1'b1;
        mon(8);
        chk(n, 0);
        pin_hold(8);
        wt(1'b0, 10);
        chk(core_reset, 1'b0);
        stat(cause_pin_run, 1'b1, 1'b1);
    endtask

    task t_wdt_run;
        wdog();
        wt(1'b1, 5);
        chk(core_reset, 1'b1);
        wt(1'b0, 3000);
        chk(32'(n < 20), 32'h1);
        stat(cause_watchdog_run, 1'b0, 1'b1);
    endtask

    task t_wake;
        cfg.osc_mode_select <= high_speed_crystal_mode;
        sleep();
        wdog();
        wt(1'b1, 5);
        chk(core_reset, 1'b1);
        chk(regs_init, 1'b0);
        wt(1'b0, 3000);
        chk(32'(n >= 2040 && n < 3000), 32'h1);
        stat(cause_watchdog_wake, 1'b0, 1'b0);
    endtask

    task t_pin_sleep;
        cfg.osc_mode_select <= low_power_crystal_mode;
        sleep();
        pin_hold(8);
        wt(1'b0, 3000);
        chk(32'(n >= 2000 && n < 3000), 32'h1);
        stat(cause_pin_sleep, 1'b1, 1'b0);
    endtask

    task t_brownout;
        cfg <= cfg_s'{1'b1, 1'b1, low_power_crystal_mode};
        low_supply <= 1'b1;
        mon(500);
        chk(n, 0);
        @(posedge ref_clk);
        low_supply <= 1'b0;
        @(posedge ref_clk);
        low_supply <= 1'b1;
        mon(1990);
        chk(n, 0);
        wt(1'b1, 30);
        chk(core_reset, 1'b1);
        mon(200);
        chk(n, 200);
        @(posedge ref_clk);
        low_supply <= 1'b0;
        mon(20);
        chk(n, 20);
        @(posedge ref_clk);
        low_supply <= 1'b1;
        repeat (3) @(posedge ref_clk);
        low_supply <= 1'b0;
        wt(1'b0, 300);
        chk(32'(n >= 36 && n < 300), 32'h1);
        stat(cause_brownout, 1'b1, 1'b1);
    endtask

    task t_rc;
        cfg <= cfg_s'{1'b0, 1'b1, resistor_capacitor_mode};
        @(posedge ref_clk);
        supply_rise <= 1'b1;
        @(posedge ref_clk);
        supply_rise <= 1'b0;
        wt(1'b1, 10);
        chk(core_reset, 1'b1);
        wt(1'b0, 100);
        chk(32'(n < 20), 32'h1);
        kv = 1'b0;
        stat(cause_power_on, 1'b1, 1'b1);
    endtask

    // ****************************************
    // run control
    // ****************************************
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // 50 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // hang guard, far above the expected run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        {nrst, supply_rise, low_supply, wdt, avs_read, avs_write} = 6'h0;
        pin_n = 1'b1;
        kv = 1'b0;
        cfg = cfg_s'{1'b0, 1'b0, standard_crystal_mode};
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_power_on();
        t_bus();
        t_pin_run();
        t_wdt_run();
        t_wake();
        t_pin_sleep();
        t_brownout();
        t_rc();
        conclude();
    end
endmodule

`default_nettype wire
